// *** common/tps_pkg.sv ***
// tps_pkg: constants and types for the timer 4..7 prescaler block
// assumes one 40 MHz system clock and a classic wishbone bus
`default_nettype none
package tps_pkg;
   // bus geometry: byte address is four times the register index
   localparam int ADR_W = 18;
   localparam int IDX_W = 16;
   localparam logic [IDX_W-1:0] IDX_CTRL45 = 16'hFF24;
   localparam logic [IDX_W-1:0] IDX_CTRL67 = 16'hFF25;
   localparam logic [IDX_W-1:0] IDX_SRC = 16'hFF27;
   // field positions inside both control registers
   localparam int GATE_HI = 7;
   localparam int RATIO_HI = 4;
   localparam int GATE_LO = 3;
   localparam int RATIO_LO = 0;
   localparam int RATIO_W = 3;
   localparam int SRC_W = 4;
   localparam int CNT_W = 12;
   localparam int NTIM = 4;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [SRC_W-1:0] SRC_RST = 4'h0;
   // divisors indexed by ratio code, high and low speed source
   localparam logic [12:0] HS_DIV [8] = '{
      13'h0001, 13'h0002, 13'h0008, 13'h0020,
      13'h0040, 13'h0100, 13'h0400, 13'h1000};
   localparam logic [12:0] LS_DIV [8] = '{
      13'h0001, 13'h0002, 13'h0004, 13'h0008,
      13'h0010, 13'h0020, 13'h0040, 13'h0080};
   // software visible registers
   typedef struct packed {
      logic [7:0] ctrl45;
      logic [7:0] ctrl67;
      logic [SRC_W-1:0] src;
   } tps_regs_t;
   // whole state of the block
   typedef struct packed {
      tps_regs_t r;
      logic [2:0] hs;
      logic [2:0] ls;
      logic [NTIM-1:0][CNT_W-1:0] cnt;
      logic [NTIM-1:0] tick;
      logic ack;
      logic [7:0] rdat;
   } tps_state_t;
endpackage : tps_pkg
`default_nettype wire

// *** design/tps_prescaler.sv ***
// tps_prescaler: prescaler gating, ratio and source for timers 4 to 7
// assumes a classic wishbone master on clk_i; both oscillators arrive
// as asynchronous pins well below half the system clock rate
// Behaviour
// - timer 5 gets its prescaled clock only while its gate bit is 1, reset 0.
// - timer 4 has its own read/write gate bit, on at 1, off at 0, reset 0.
// - the timer 7 gate bit is bit 7 of the second register, reset 0.
// - the timer 6 gate bit is bit 3 of the second register, reset 0.
// - timer 5 ratio is a 3-bit field at bits 6..4 of the first register.
// - timer 7 ratio is a 3-bit field at bits 6..4 of the second register.
// - timer 6 ratio is a 3-bit field at bits 2..0 of the second register.
// - timer 4 ratio is a 3-bit field at bits 2..0 of the first register.
// - on the fast source codes 111..100 divide by 4096, 1024, 256, 64.
// - codes 011..000 divide fast by 32, 8, 2, 1 and slow by 8, 4, 2, 1.
// - a per-timer source bit picks the slow source at 1, fast at 0.
`default_nettype none
module tps_prescaler (
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tps_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // oscillator pins
   input wire logic high_speed_oscillator_i,
   input wire logic low_speed_oscillator_i,
   // prescaled clock enables, bit 0 is timer 4
   output logic [tps_pkg::NTIM-1:0] tick_o
);

   tps_pkg::tps_state_t s_q;
   tps_pkg::tps_state_t s_d;

   logic req;
   logic wr_ok;
   logic hit45;
   logic hit67;
   logic hitsrc;
   logic wr45;
   logic wr67;
   logic wrsrc;
   logic hs_edge;
   logic ls_edge;
   logic [tps_pkg::NTIM-1:0] gate;
   logic [tps_pkg::NTIM-1:0] pick;
   logic [tps_pkg::NTIM-1:0] src_edge;
   logic [tps_pkg::NTIM-1:0][tps_pkg::RATIO_W-1:0] ratio;
   logic [tps_pkg::NTIM-1:0][tps_pkg::CNT_W-1:0] term;

   // terminal count for a ratio code on the chosen source
   function automatic logic [tps_pkg::CNT_W-1:0] term_of(
      input logic [tps_pkg::RATIO_W-1:0] code,
      input logic low
   );
      logic [12:0] div;
      div = low ? tps_pkg::LS_DIV[code] : tps_pkg::HS_DIV[code];
      return div[tps_pkg::CNT_W-1:0] - 12'h001;
   endfunction : term_of

   // register index match, low two address bits ignored
   function automatic logic idx_hit(
      input logic [tps_pkg::ADR_W-1:0] adr,
      input logic [tps_pkg::IDX_W-1:0] idx
   );
      return adr[tps_pkg::ADR_W-1:2] == idx;
   endfunction : idx_hit

   // bus decode; a write lands on the edge that sees ack high
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_ok = req & wb_we_i & s_q.ack & wb_sel_i[0];
   assign hit45 = idx_hit(wb_adr_i, tps_pkg::IDX_CTRL45);
   assign hit67 = idx_hit(wb_adr_i, tps_pkg::IDX_CTRL67);
   assign hitsrc = idx_hit(wb_adr_i, tps_pkg::IDX_SRC);
   assign wr45 = wr_ok & hit45;
   assign wr67 = wr_ok & hit67;
   assign wrsrc = wr_ok & hitsrc;

   // rising edges seen on the second and third sync stages only
   assign hs_edge = s_q.hs[1] & ~s_q.hs[2];
   assign ls_edge = s_q.ls[1] & ~s_q.ls[2];

   // per-timer fields pulled out of the two control registers
   // timer 4 gate
   assign gate[0] = s_q.r.ctrl45[tps_pkg::GATE_LO];
   assign gate[1] = s_q.r.ctrl45[tps_pkg::GATE_HI];
   assign gate[2] = s_q.r.ctrl67[tps_pkg::GATE_LO];
   assign gate[3] = s_q.r.ctrl67[tps_pkg::GATE_HI];
   assign ratio[0] = s_q.r.ctrl45[tps_pkg::RATIO_LO +: tps_pkg::RATIO_W];
   assign ratio[1] = s_q.r.ctrl45[tps_pkg::RATIO_HI +: tps_pkg::RATIO_W];
   assign ratio[2] = s_q.r.ctrl67[tps_pkg::RATIO_LO +: tps_pkg::RATIO_W];
   assign ratio[3] = s_q.r.ctrl67[tps_pkg::RATIO_HI +: tps_pkg::RATIO_W];
   assign pick = s_q.r.src;

   // source choice and divisor for each timer
   for (genvar g = 0; g < tps_pkg::NTIM; g++) begin : g_tim
      assign src_edge[g] = pick[g] ? ls_edge : hs_edge;
      assign term[g] = term_of(ratio[g], pick[g]);
   end

   // next state: bus, synchronisers, prescale counters
   always_comb begin
      s_d = s_q;
      s_d.hs = {s_q.hs[1:0], high_speed_oscillator_i};
      s_d.ls = {s_q.ls[1:0], low_speed_oscillator_i};
      // one-cycle ack, dropped in the cycle after it was given
      s_d.ack = req & ~s_q.ack;
      if (req & ~s_q.ack) begin
         if (hit45) begin
            s_d.rdat = s_q.r.ctrl45;
         end else if (hit67) begin
            s_d.rdat = s_q.r.ctrl67;
         end else if (hitsrc) begin
            s_d.rdat = {4'h0, s_q.r.src};
         end else begin
            s_d.rdat = 8'h00;
         end
      end
      if (wr45) begin
         s_d.r.ctrl45 = wb_dat_i[7:0];
      end
      if (wr67) begin
         s_d.r.ctrl67 = wb_dat_i[7:0];
      end
      if (wrsrc) begin
         s_d.r.src = wb_dat_i[tps_pkg::SRC_W-1:0];
      end
      // a disabled timer holds its divider in reset so a later
      // enable starts a full period rather than a stray short one
      for (int i = 0; i < tps_pkg::NTIM; i++) begin
         s_d.tick[i] = 1'b0;
         if (!gate[i]) begin
            s_d.cnt[i] = '0;
         end else if (src_edge[i]) begin
            // >= so a ratio cut mid-period does not wrap to 4096
            if (s_q.cnt[i] >= term[i]) begin
               s_d.cnt[i] = '0;
               s_d.tick[i] = 1'b1;
            end else begin
               s_d.cnt[i] = s_q.cnt[i] + 12'h001;
            end
         end
      end
   end

   // state register; sync stages also cleared so no edge at release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '{
            r: '{ctrl45: tps_pkg::CTRL_RST,
                  ctrl67: tps_pkg::CTRL_RST,
                  src: tps_pkg::SRC_RST},
            hs: 3'h0,
            ls: 3'h0,
            cnt: '0,
            tick: 4'h0,
            ack: 1'b0,
            rdat: 8'h00};
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flip-flops
   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = {24'h000000, s_q.rdat};
   assign tick_o = s_q.tick;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_t5_reset_clear: assert property (
      disable iff (1'b0) rst_i |=> s_q.r.ctrl45 == 8'h00 &&
      s_q.r.ctrl67 == 8'h00 && s_q.r.src == 4'h0)
      else $error("control fields not cleared by reset");

   a_t5_gate_off: assert property (
      !gate[1] |=> !tick_o[1])
      else $error("timer 5 tick while its gate is off");

   a_t4_gate_off: assert property (
      !gate[0] |=> !tick_o[0])
      else $error("timer 4 tick while its gate is off");

   a_t4_gate_wr: assert property (
      wr45 |=> gate[0] == $past(wb_dat_i[3]))
      else $error("timer 4 gate did not take written value");

   a_t7_gate_wr: assert property (
      wr67 |=> gate[3] == $past(wb_dat_i[7]))
      else $error("timer 7 gate not at bit 7");

   a_t7_gate_off: assert property (
      !gate[3] |=> !tick_o[3])
      else $error("timer 7 tick while its gate is off");

   a_t6_gate_wr: assert property (
      wr67 ##1 !wr67 [*2] |-> gate[2] == $past(wb_dat_i[3], 2))
      else $error("timer 6 gate not held at bit 3");

   a_t5_ratio_wr: assert property (
      wr45 |=> ratio[1] == $past(wb_dat_i[6:4]))
      else $error("timer 5 ratio not at bits 6..4");

   a_t7_ratio_wr: assert property (
      wr67 |=> ratio[3] == $past(wb_dat_i[6:4]))
      else $error("timer 7 ratio not at bits 6..4");

   a_t6_ratio_wr: assert property (
      wr67 |=> ratio[2] == $past(wb_dat_i[2:0]))
      else $error("timer 6 ratio not at bits 2..0");

   a_t4_ratio_rd: assert property (
      req & ~wb_we_i & ~s_q.ack & hit45 |=>
      wb_ack_o && wb_dat_o[2:0] == $past(ratio[0]))
      else $error("timer 4 ratio readback wrong");

   a_hs_div_top: assert property (
      !pick[0] && ratio[0] == 3'h7 |-> term[0] == 12'hFFF &&
      term_of(3'h6, 1'b0) == 12'h3FF && term_of(3'h5, 1'b0) == 12'h0FF &&
      term_of(3'h4, 1'b0) == 12'h03F)
      else $error("fast source divisor wrong");

   a_ls_div_top: assert property (
      pick[1] && ratio[1] == 3'h4 |-> term[1] == 12'h00F &&
      term_of(3'h7, 1'b1) == 12'h07F && term_of(3'h5, 1'b1) == 12'h01F)
      else $error("slow source divisor wrong");

   a_low_codes: assert property (
      ratio[2] == 3'h0 |-> term[2] == 12'h000 &&
      term_of(3'h3, 1'b0) == 12'h01F && term_of(3'h2, 1'b1) == 12'h003 &&
      term_of(3'h1, 1'b0) == 12'h001)
      else $error("low ratio code divisor wrong");

   a_src_hold: assert property (
      gate[0] && !src_edge[0] |=> s_q.cnt[0] == $past(s_q.cnt[0]) &&
      !tick_o[0])
      else $error("timer 4 counted without a source edge");

   a_tick_cause: assert property (
      tick_o[3] |-> $past(src_edge[3]) && $past(gate[3]))
      else $error("timer 7 tick without chosen edge");

   a_src_read_zero: assert property (
      wb_ack_o && hitsrc |-> wb_dat_o[7:4] == 4'h0)
      else $error("source register upper bits not zero");

   a_t6_gate_off: assert property (
      !gate[2] |=> !tick_o[2])
      else $error("timer 6 tick while its gate is off");

   a_t5_gate_wr: assert property (
      wr45 |=> gate[1] == $past(wb_dat_i[7]))
      else $error("timer 5 gate not at bit 7");

   // gate off holds the divider at zero
   a_t5_cnt_clear: assert property (
      !gate[1] |=> s_q.cnt[1] == 12'h000)
      else $error("timer 5 divider runs while gated");

   // gate off holds the divider at zero
   a_t7_cnt_clear: assert property (
      !gate[3] |=> s_q.cnt[3] == 12'h000)
      else $error("timer 7 divider runs while gated");

   a_t4_ratio_wr: assert property (
      wr45 |=> ratio[0] == $past(wb_dat_i[2:0]))
      else $error("timer 4 ratio not at bits 2..0");

   // source picks land in bits 3..0
   a_src_wr: assert property (
      wrsrc |=> pick == $past(wb_dat_i[3:0]))
      else $error("source picks did not take written value");

   a_src_rd: assert property (
      req && !wb_we_i && !s_q.ack && hitsrc |=>
      wb_dat_o[3:0] == $past(pick))
      else $error("source picks readback wrong");

   // a tick only at the terminal count
   a_tick_term: assert property (
      tick_o[0] |-> $past(s_q.cnt[0]) >= $past(term[0]))
      else $error("timer 4 tick before terminal count");

   // divider steps by one per chosen edge
   a_cnt_step: assert property (
      gate[0] && src_edge[0] && s_q.cnt[0] < term[0] |=>
      s_q.cnt[0] == $past(s_q.cnt[0]) + 12'h001)
      else $error("timer 4 divider did not step by one");

   // byte lane 0 off: nothing stored
   a_sel_no_store: assert property (
      req && wb_we_i && s_q.ack && !wb_sel_i[0] |=> s_q.r == $past(s_q.r))
      else $error("write stored with byte lane 0 off");

   // unmapped index reads zero
   a_unmapped_zero: assert property (
      req && !s_q.ack && !hit45 && !hit67 && !hitsrc |=>
      wb_dat_o == 32'h00000000)
      else $error("unmapped index did not read zero");

   // single-cycle ack on the bus
   a_ack_single: assert property (
      req && !s_q.ack |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle");

endmodule : tps_prescaler
`default_nettype wire

// *** sim/tps_prescaler_tb_top.sv ***
// tps_prescaler_tb_top: self-checking bench for the timer prescaler
// assumes a one-cycle bus answer and ticks within five cycles of an edge
`default_nettype none
module tps_prescaler_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int t; logic [2:0] code; int fdiv; int sdiv;} tps_case_t;
   typedef struct {logic [17:0] a; logic [7:0] w; logic [7:0] e;} tps_rw_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [17:0] adr = '0;
   logic [3:0] sel = '0;
   logic [31:0] wdat = '0;
   logic [31:0] rdat;
   logic ack;
   logic hs = 1'b0;
   logic ls = 1'b0;
   logic [3:0] tick;
   logic [31:0] rdat_dummy;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc_n = 0;
   int tick_n [4] = '{0, 0, 0, 0};
   // ratio rows: timer, code, fast and slow divisors
   tps_case_t rows [11] = '{
      '{0, 3'h0, 1, 1}, '{0, 3'h1, 2, 2}, '{0, 3'h2, 8, 4},
      '{0, 3'h3, 32, 8}, '{0, 3'h4, 64, 16}, '{0, 3'h5, 256, 32},
      '{0, 3'h6, 1024, 64}, '{0, 3'h7, 4096, 128}, '{1, 3'h4, 64, 16},
      '{2, 3'h4, 64, 16}, '{3, 3'h2, 8, 4}};
   // register rows: address, write value, read back
   tps_rw_t rw [4] = '{'{18'h3FC90, 8'hA5, 8'hA5},
      '{18'h3FC94, 8'h5A, 8'h5A}, '{18'h3FC9C, 8'hFF, 8'h0F},
      '{18'h3FC98, 8'hFF, 8'h00}};

   always #12.5 clk_i = ~clk_i;

   tps_prescaler u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .high_speed_oscillator_i(hs),
      .low_speed_oscillator_i(ls), .tick_o(tick));

   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   // tick counting and hang guard; the ceiling covers the longest ratio
   always @(posedge clk_i) begin
      cyc_n++;
      for (int i = 0; i < 4; i++) begin
         if (tick[i] === 1'b1) tick_n[i]++;
      end
      if (cyc_n > 60000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [17:0] a,
         input logic [7:0] d, input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1);
      q = rdat;
      chk("bus ack cycles", 32'h2, 32'(n));
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : bus

   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'h1, q);
   endtask : wr

   task automatic rd(input logic [17:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, 4'h1, q);
      chk("read data", {24'h000000, e}, q);
   endtask : rd

   // source edges: three cycles high, four low, slower than clk/2
   task automatic pulse(input logic slow, input int n);
      repeat (n) begin
         @(posedge clk_i);
         hs <= ~slow;
         ls <= slow;
         repeat (3) @(posedge clk_i);
         hs <= 1'b0;
         ls <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
   endtask : pulse

   // gate and ratio set, then count edges up to the first tick
   task automatic run_case(input tps_case_t c, input logic slow);
      logic [17:0] a;
      logic [7:0] v;
      int dv;
      a = (c.t < 2) ? 18'h3FC90 : 18'h3FC94;
      v = (c.t % 2 == 1) ? {1'b1, c.code, 4'h0} : {4'h0, 1'b1, c.code};
      dv = slow ? c.sdiv : c.fdiv;
      wr(18'h3FC90, 8'h00);
      wr(18'h3FC94, 8'h00);
      wr(18'h3FC9C, slow ? (8'h01 << c.t) : 8'h00);
      wr(a, v);
      rd(a, v);
      tick_n = '{0, 0, 0, 0};
      pulse(slow, dv - 1);
      chk("early tick", 32'h0, 32'(tick_n[c.t]));
      pulse(slow, 1);
      chk("tick", 32'h1, 32'(tick_n[c.t]));
      chk("all ticks", 32'h1, 32'(tick_n.sum()));
      $display("ratio test timer %0d code %0d slow %0b done", c.t + 4,
         c.code, slow);
   endtask : run_case

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rw[i]) begin
         wr(rw[i].a, rw[i].w);
         rd(rw[i].a, rw[i].e);
      end
      $display("register table test done");
      foreach (rows[i]) begin
         run_case(rows[i], 1'b0);
         run_case(rows[i], 1'b1);
      end
      // all gates off: no tick on any timer
      wr(18'h3FC90, 8'h00);
      wr(18'h3FC94, 8'h00);
      wr(18'h3FC9C, 8'h00);
      tick_n = '{0, 0, 0, 0};
      pulse(1'b0, 3);
      chk("gated ticks", 32'h0, 32'(tick_n.sum()));
      $display("gate off test done");
      // byte lane disabled: write must not land
      bus(1'b1, 18'h3FC94, 8'hFF, 4'h0, rdat_dummy);
      rd(18'h3FC94, 8'h00);
      // reset in mid-run clears every field
      wr(18'h3FC90, 8'hFF);
      wr(18'h3FC94, 8'hFF);
      wr(18'h3FC9C, 8'h0F);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(18'h3FC90, 8'h00);
      rd(18'h3FC94, 8'h00);
      rd(18'h3FC9C, 8'h00);
      $display("reset test done");
      stop_test();
   end
endmodule : tps_prescaler_tb_top
`default_nettype wire
